// ### inc/csd_regs.svh
// Register map, field positions, reset values and timing of the clock block
// Assumes a 25 MHz mclk and word addressing on the register bus
`ifndef CSD_REGS_SVH
`define CSD_REGS_SVH
// Word indexes
`define CSD_IDX_PROTECT 3'h0
`define CSD_IDX_CTRL_A 3'h1
`define CSD_IDX_CTRL_B 3'h2
`define CSD_IDX_OSD 3'h3
`define CSD_IDX_VDPE 3'h4
`define CSD_IDX_FAST_A 3'h5
`define CSD_IDX_STATUS 3'h6
// write_protect_register
`define CSD_PR_CLK 0
`define CSD_PR_VOLT 3
// system_clock_control_a
`define CSD_CA_MAIN_STOP 5
`define CSD_CA_DIV8 6
// system_clock_control_b
`define CSD_CB_ALL_STOP 0
`define CSD_CB_PIN_MODE 3
`define CSD_CB_LSO_STOP 4
`define CSD_CB_DRIVE_HI 5
`define CSD_CB_DIV_LO 6
`define CSD_CB_DIV_HI 7
// oscillation_stop_detect_control
`define CSD_OD_EN 0
`define CSD_OD_IRQ_EN 1
`define CSD_OD_SEL 2
`define CSD_OD_STOPPED 3
// voltage_detect_power_enable
`define CSD_VD_MON0 5
// fast_osc_control_a
`define CSD_FA_ON 0
`define CSD_FA_SEL 1
// Reset values
`define CSD_RST_CTRL_A 8'h60
`define CSD_RST_CTRL_B 8'h20
`define CSD_RST_OSD 8'h04
`define CSD_RST_VDPE 8'h00
`define CSD_RST_FAST_A 8'h00
// Timing
`define CSD_MCLK_KHZ 25000
`define CSD_DET_DELAY_NS 100000
`define CSD_STOP_TMO_NS 2000
`define CSD_NS_TO_CYC(t) (((t) * (`CSD_MCLK_KHZ / 1000) + 999) / 1000)
`endif

// ### inc/csd_pkg.sv
// Types shared by the clock block
// Assumes nothing beyond the register header
package csd_pkg;
    // CPU clock divide ratio
    typedef enum logic [2:0] {
        CSD_DIV1, CSD_DIV2, CSD_DIV4, CSD_DIV8, CSD_DIV16
    } csd_div_type;
    // Controls that go to the clock tree and oscillators
    typedef struct packed {
        logic main_buf_en;
        logic main_clk_pass;
        logic feedback_en;
        logic drive_high;
        logic low_osc_en;
        logic fast_osc_en;
        logic onchip_fast;
        logic onchip_sel;
        csd_div_type cpu_div;
        logic stop_mode;
    } csd_clk_ctl_type;
endpackage : csd_pkg

// ### core/csd_clock_ctrl.sv
// Clock source selection, stop mode, oscillation stop detection and
// voltage monitor power enables, with an Avalon-MM register slave.
// Assumes a 25 MHz mclk, a same-domain wake event and watchdog flag, and
// the main clock pin arriving asynchronously.
//
// The address map and register access over Avalon-MM are this design's own decisions.
`include "csd_regs.svh"

module csd_clock_ctrl #(
    parameter int DET_DELAY_CYC = `CSD_NS_TO_CYC(`CSD_DET_DELAY_NS),
    parameter int STOP_TMO_CYC = `CSD_NS_TO_CYC(`CSD_STOP_TMO_NS)
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic [2:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic main_clock_in_pin,
    output logic main_clock_out_pin_o,
    output logic main_clock_out_pin_oe_n,
    input wire logic stop_wake_event,
    input wire logic wdt_protect_mode,
    output csd_pkg::csd_clk_ctl_type clk_ctl,
    output logic [2:0] monitor_active,
    output logic osc_pins_as_inputs,
    output logic stop_detect_irq_en
);

    // ******************************
    // Bus slave
    // ******************************
    logic wait_r;
    logic [31:0] rdata_r;
    logic wr_go;
    logic [7:0] wd;
    logic [7:0] prot_r;
    logic [7:0] ca_r;
    logic [7:0] cb_r;
    logic [7:0] od_r;
    logic [7:0] vd_r;
    logic [7:0] fa_r;
    logic stopped_r;
    logic [2:0] mon_r;
    logic clk_we;
    logic volt_we;
    logic stop_det;
    logic osd_stat;
    logic [7:0] status;
    logic stop_enter;
    // Write lands at the edge where waitrequest is low
    assign wr_go = avs_write && !wait_r && avs_byteenable[0];
    assign wd = avs_writedata[7:0];
    assign clk_we = prot_r[`CSD_PR_CLK];
    assign volt_we = prot_r[`CSD_PR_VOLT];
    // Stopped status valid only with detection enabled
    assign osd_stat = stopped_r && od_r[`CSD_OD_EN];
    assign status = {3'h0, clk_ctl.stop_mode, clk_ctl.main_clk_pass, mon_r};
    // Waitrequest drops for one cycle per request
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
            wait_r <= 1'b1;
        else
            wait_r <= !((avs_read || avs_write) && wait_r);
    end
    // Read data captured while waitrequest is still high
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
            rdata_r <= 32'h0;
        else if (avs_read && wait_r)
        begin
            unique case (avs_address)
                `CSD_IDX_PROTECT: rdata_r <= {24'h0, prot_r};
                `CSD_IDX_CTRL_A: rdata_r <= {24'h0, ca_r};
                `CSD_IDX_CTRL_B: rdata_r <= {24'h0, cb_r};
                `CSD_IDX_OSD: rdata_r <= {28'h0, osd_stat, od_r[2:0]};
                `CSD_IDX_VDPE: rdata_r <= {24'h0, vd_r};
                `CSD_IDX_FAST_A: rdata_r <= {30'h0, fa_r[1:0]};
                `CSD_IDX_STATUS: rdata_r <= {24'h0, status};
                default: rdata_r <= 32'h0; // Unmapped reads zero
            endcase
        end
    end
    assign avs_waitrequest = wait_r;
    assign avs_readdata = rdata_r;
    // ******************************
    // Protection register
    // ******************************
    // Write enables themselves are never protected
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
            prot_r <= 8'h0;
        else if (wr_go && avs_address == `CSD_IDX_PROTECT)
        begin
            prot_r <= 8'h0;
            prot_r[`CSD_PR_CLK] <= wd[`CSD_PR_CLK];
            prot_r[`CSD_PR_VOLT] <= wd[`CSD_PR_VOLT];
        end
    end
    // ******************************
    // Control register a
    // ******************************
    logic wr_ca;
    assign wr_ca = wr_go && avs_address == `CSD_IDX_CTRL_A && clk_we;
    // Main stop resets to 1, divide-by-eight resets to 1
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
            ca_r <= `CSD_RST_CTRL_A;
        else
        begin
            if (wr_ca)
            begin
                ca_r[`CSD_CA_MAIN_STOP] <= wd[`CSD_CA_MAIN_STOP];
                ca_r[`CSD_CA_DIV8] <= wd[`CSD_CA_DIV8];
            end
            if (stop_enter)
                ca_r[`CSD_CA_DIV8] <= 1'b1;
        end
    end
    // ******************************
    // Control register b
    // ******************************
    logic wr_cb;
    logic sel_fall;
    logic sel_d_r;
    assign wr_cb = wr_go && avs_address == `CSD_IDX_CTRL_B && clk_we;
    // Watchdog protect keeps writes from changing the all-stop bit
    assign stop_enter = wr_cb && wd[`CSD_CB_ALL_STOP]
        && !cb_r[`CSD_CB_ALL_STOP] && !wdt_protect_mode;
    assign sel_fall = sel_d_r && !od_r[`CSD_OD_SEL];
    // Select delayed for the low-speed stop edge
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
            sel_d_r <= 1'b1;
        else
            sel_d_r <= od_r[`CSD_OD_SEL];
    end

    // Stop mode, pin mode latch, drive, divider and low-speed stop
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
            cb_r <= `CSD_RST_CTRL_B;
        else
        begin
            if (wr_cb)
            begin
                if (!wdt_protect_mode)
                    cb_r[`CSD_CB_ALL_STOP] <= wd[`CSD_CB_ALL_STOP];
                if (wd[`CSD_CB_PIN_MODE])
                    cb_r[`CSD_CB_PIN_MODE] <= 1'b1;
                cb_r[`CSD_CB_DRIVE_HI] <= wd[`CSD_CB_DRIVE_HI];
                cb_r[`CSD_CB_DIV_LO] <= wd[`CSD_CB_DIV_LO];
                cb_r[`CSD_CB_DIV_HI] <= wd[`CSD_CB_DIV_HI];
                if (!wdt_protect_mode && !od_r[`CSD_OD_SEL])
                    cb_r[`CSD_CB_LSO_STOP] <= wd[`CSD_CB_LSO_STOP];
            end
            if (stop_enter)
                cb_r[`CSD_CB_DRIVE_HI] <= 1'b1;
            if (cb_r[`CSD_CB_ALL_STOP] && stop_wake_event)
                cb_r[`CSD_CB_ALL_STOP] <= 1'b0;
            // On-chip select holds the low-speed stop bit clear
            if (od_r[`CSD_OD_SEL])
                cb_r[`CSD_CB_LSO_STOP] <= 1'b0;
            else if (sel_fall)
                cb_r[`CSD_CB_LSO_STOP] <= 1'b1;
        end
    end
    // ******************************
    // Oscillation stop detection
    // ******************************
    logic pin_s1_r;
    logic pin_s2_r;
    logic pin_s3_r;
    logic [15:0] idle_r;
    logic wr_od;
    logic det_armed;
    assign wr_od = wr_go && avs_address == `CSD_IDX_OSD && clk_we;
    assign det_armed = od_r[`CSD_OD_EN] && clk_ctl.main_clk_pass;
    assign stop_det = det_armed && idle_r == 16'(STOP_TMO_CYC);
    // Pin synchroniser, third stage for edges
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            pin_s1_r <= 1'b0;
            pin_s2_r <= 1'b0;
            pin_s3_r <= 1'b0;
        end
        else
        begin
            pin_s1_r <= main_clock_in_pin;
            pin_s2_r <= pin_s1_r;
            pin_s3_r <= pin_s2_r;
        end
    end

    // Cycles since the last main clock edge
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
            idle_r <= 16'h0;
        else if (!det_armed || pin_s2_r != pin_s3_r)
            idle_r <= 16'h0;
        else if (idle_r != 16'(STOP_TMO_CYC))
            idle_r <= idle_r + 16'h1;
    end

    // Stopped flag, zero while the detect field is 00b
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
            stopped_r <= 1'b0;
        else if (od_r[1:0] == 2'h0)
            stopped_r <= 1'b0;
        else if (stop_det)
            stopped_r <= 1'b1;
        else if (pin_s2_r != pin_s3_r)
            stopped_r <= 1'b0;
    end

    // Detect control, automatic fall back to the on-chip osc
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
            od_r <= `CSD_RST_OSD;
        else
        begin
            if (wr_od)
            begin
                od_r[`CSD_OD_EN] <= wd[`CSD_OD_EN];
                od_r[`CSD_OD_IRQ_EN] <= wd[`CSD_OD_IRQ_EN];
                if (wd[`CSD_OD_SEL] || !osd_stat)
                    od_r[`CSD_OD_SEL] <= wd[`CSD_OD_SEL];
            end
            if (stop_det && od_r[1:0] == 2'h3)
                od_r[`CSD_OD_SEL] <= 1'b1;
        end
    end
    // ******************************
    // Voltage monitor power enables
    // ******************************
    logic wr_vd;
    assign wr_vd = wr_go && avs_address == `CSD_IDX_VDPE && volt_we;
    // Power enable register
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
            vd_r <= `CSD_RST_VDPE;
        else if (wr_vd)
            vd_r <= wd;
    end

    // One settling counter per monitor
    for (genvar i = 0; i < 3; i++)
    begin : g_mon
        logic [15:0] cnt_r;
        always_ff @(posedge mclk or posedge reset)
        begin
            if (reset)
            begin
                cnt_r <= 16'h0;
                mon_r[i] <= 1'b0;
            end
            else if (!vd_r[`CSD_VD_MON0 + i])
            begin
                cnt_r <= 16'h0;
                mon_r[i] <= 1'b0;
            end
            else if (cnt_r == 16'(DET_DELAY_CYC))
                mon_r[i] <= 1'b1;
            else
                cnt_r <= cnt_r + 16'h1;
        end
    end
    // ******************************
    // Fast oscillator control
    // ******************************
    logic wr_fa;
    assign wr_fa = wr_go && avs_address == `CSD_IDX_FAST_A && clk_we;
    // Fast osc on and fast or slow select
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
            fa_r <= `CSD_RST_FAST_A;
        else if (wr_fa)
            fa_r <= {6'h0, wd[`CSD_FA_SEL], wd[`CSD_FA_ON]};
    end
    // ******************************
    // Clock tree outputs
    // ******************************
    logic stop_m;
    csd_pkg::csd_div_type div_nxt;
    assign stop_m = cb_r[`CSD_CB_ALL_STOP];
    // CPU divide ratio
    always_comb
    begin
        if (ca_r[`CSD_CA_DIV8])
            div_nxt = csd_pkg::CSD_DIV8;
        else
        begin
            unique case ({cb_r[`CSD_CB_DIV_HI], cb_r[`CSD_CB_DIV_LO]})
                2'h0: div_nxt = csd_pkg::CSD_DIV1;
                2'h1: div_nxt = csd_pkg::CSD_DIV2;
                2'h2: div_nxt = csd_pkg::CSD_DIV4;
                2'h3: div_nxt = csd_pkg::CSD_DIV16;
            endcase
        end
    end

    // Registered clock controls
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            clk_ctl <= '0;
            clk_ctl.low_osc_en <= 1'b1;
            clk_ctl.onchip_sel <= 1'b1;
            clk_ctl.drive_high <= 1'b1;
            clk_ctl.cpu_div <= csd_pkg::CSD_DIV8;
        end
        else
        begin
            clk_ctl.main_buf_en <= !ca_r[`CSD_CA_MAIN_STOP]
                && cb_r[`CSD_CB_PIN_MODE] && !stop_m;
            clk_ctl.main_clk_pass <= cb_r[`CSD_CB_PIN_MODE]
                && !stop_m;
            clk_ctl.feedback_en <= !stop_m;
            clk_ctl.drive_high <= cb_r[`CSD_CB_DRIVE_HI];
            clk_ctl.low_osc_en <= !cb_r[`CSD_CB_LSO_STOP]
                && !stop_m;
            clk_ctl.fast_osc_en <= fa_r[`CSD_FA_ON] && !stop_m;
            clk_ctl.onchip_fast <= fa_r[`CSD_FA_SEL];
            clk_ctl.onchip_sel <= od_r[`CSD_OD_SEL];
            clk_ctl.cpu_div <= div_nxt;
            clk_ctl.stop_mode <= stop_m;
        end
    end
    // ******************************
    // Pins and flags
    // ******************************
    // Output pin high in stop mode with pin mode set, else input
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            main_clock_out_pin_o <= 1'b0;
            main_clock_out_pin_oe_n <= 1'b1;
            osc_pins_as_inputs <= 1'b1;
            monitor_active <= 3'h0;
            stop_detect_irq_en <= 1'b0;
        end
        else
        begin
            main_clock_out_pin_o <= stop_m && cb_r[`CSD_CB_PIN_MODE];
            main_clock_out_pin_oe_n <= !(stop_m
                && cb_r[`CSD_CB_PIN_MODE]);
            osc_pins_as_inputs <= ca_r[`CSD_CA_MAIN_STOP]
                && !cb_r[`CSD_CB_PIN_MODE];
            monitor_active <= mon_r;
            stop_detect_irq_en <= od_r[`CSD_OD_IRQ_EN];
        end
    end

endmodule : csd_clock_ctrl

// ### verif/csd_clock_ctrl_chk.sv
// Port checker for the clock control block, bound to its top module
// Assumes csd_pkg and the register header are compiled first
`include "csd_regs.svh"
// ****************************************
// Checker
// ****************************************
module csd_clock_ctrl_chk #(
    parameter int DET_DELAY_CYC = 5,
    parameter int STOP_TMO_CYC = 8
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic [2:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic avs_waitrequest,
    input wire logic main_clock_out_pin_o,
    input wire logic main_clock_out_pin_oe_n,
    input wire csd_pkg::csd_clk_ctl_type clk_ctl,
    input wire logic [2:0] monitor_active
);
    logic [15:0] since_en_r;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    // Cycles since the last accepted power enable write
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
            since_en_r <= 16'hffff;
        else if (avs_write && !avs_waitrequest &&
                 avs_address == `CSD_IDX_VDPE)
            since_en_r <= 16'h0000;
        else if (since_en_r != 16'hffff)
            since_en_r <= since_en_r + 16'h0001;
    end
    property p_answer_next;
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
    endproperty
    property p_wait_one;
        !avs_waitrequest |=> avs_waitrequest;
    endproperty
    property p_stop_drive;
        clk_ctl.stop_mode |-> clk_ctl.drive_high;
    endproperty
    property p_stop_div8;
        clk_ctl.stop_mode |-> clk_ctl.cpu_div == csd_pkg::CSD_DIV8;
    endproperty
    property p_stop_fb;
        $rose(clk_ctl.stop_mode) |-> !clk_ctl.feedback_en [*2];
    endproperty
    property p_stop_clocks;
        clk_ctl.stop_mode |-> !(clk_ctl.main_buf_en || clk_ctl.main_clk_pass
            || clk_ctl.low_osc_en || clk_ctl.fast_osc_en);
    endproperty
    property p_pin_high;
        !main_clock_out_pin_oe_n |-> main_clock_out_pin_o && clk_ctl.stop_mode;
    endproperty
    property p_reset_src;
        $fell(reset) |-> clk_ctl.cpu_div == csd_pkg::CSD_DIV8 &&
            clk_ctl.onchip_sel && !clk_ctl.onchip_fast;
    endproperty
    property p_reset_main;
        $fell(reset) |-> !clk_ctl.main_buf_en && !clk_ctl.main_clk_pass;
    endproperty
    property p_mon_delay;
        $rose(monitor_active[0]) |-> since_en_r >= DET_DELAY_CYC;
    endproperty
    a_answer_next: assert property (p_answer_next)
        else $error("no answer in the cycle after a request");
    a_wait_one: assert property (p_wait_one)
        else $error("waitrequest low for more than one cycle");
    a_stop_drive: assert property (p_stop_drive)
        else $error("stop mode without high drive");
    a_stop_div8: assert property (p_stop_div8)
        else $error("stop mode without divide by eight");
    a_stop_fb: assert property (p_stop_fb)
        else $error("feedback resistor on in stop mode");
    a_stop_clocks: assert property (p_stop_clocks)
        else $error("a clock runs in stop mode");
    a_pin_high: assert property (p_pin_high)
        else $error("output pin driven wrongly");
    a_reset_src: assert property (p_reset_src)
        else $error("wrong CPU clock after reset");
    a_reset_main: assert property (p_reset_main)
        else $error("main clock runs after reset");
    a_mon_delay: assert property (p_mon_delay)
        else $error("monitor started before its settling delay");
    c_stop: cover property ($rose(clk_ctl.stop_mode));
    c_mon: cover property ($rose(monitor_active[0]));
    c_read: cover property (avs_read && !avs_waitrequest);
endmodule : csd_clock_ctrl_chk

bind csd_clock_ctrl csd_clock_ctrl_chk #(.DET_DELAY_CYC(DET_DELAY_CYC),
    .STOP_TMO_CYC(STOP_TMO_CYC)) u_chk (.mclk(mclk), .reset(reset),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_waitrequest(avs_waitrequest), .clk_ctl(clk_ctl),
    .main_clock_out_pin_o(main_clock_out_pin_o),
    .main_clock_out_pin_oe_n(main_clock_out_pin_oe_n),
    .monitor_active(monitor_active));

// ### verif/tb_csd_clock_ctrl.sv
// Self-checking bench for the clock control block
// Assumes the design, its package, header and checker are compiled first
`include "csd_regs.svh"
// ****************************************
// Bench top
// ****************************************
module tb_csd_clock_ctrl;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int DET = 5;
    localparam int TMO = 8;
    logic mclk = 1'b0;
    logic reset = 1'b1;
    logic [2:0] avs_address = 3'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'h1;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic pin = 1'b0;
    logic pin_run = 1'b0;
    logic pin_o;
    logic oe_n;
    logic wake = 1'b0;
    logic wdt = 1'b0;
    csd_pkg::csd_clk_ctl_type ctl;
    logic [2:0] mon;
    logic pins_in;
    logic irq_en;
    logic [31:0] rd_v;
    logic [7:0] rst_tab [8] = '{8'h00, 8'h60, 8'h20, 8'h04,
                               8'h00, 8'h00, 8'h00, 8'h00};
    int n_errors = 0;
    int checks = 0;
    int n;
    // Clock and a toggling main clock pin
    always #20 mclk = ~mclk;
    always @(posedge mclk) if (pin_run) pin <= ~pin;
    csd_clock_ctrl #(.DET_DELAY_CYC(DET), .STOP_TMO_CYC(TMO)) uut (
        .mclk(mclk), .reset(reset), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .main_clock_in_pin(pin), .main_clock_out_pin_o(pin_o),
        .main_clock_out_pin_oe_n(oe_n), .stop_wake_event(wake),
        .wdt_protect_mode(wdt), .clk_ctl(ctl), .monitor_active(mon),
        .osc_pins_as_inputs(pins_in), .stop_detect_irq_en(irq_en));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    // One Avalon transfer, held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [2:0] a,
                       input logic [7:0] d);
        @(posedge mclk);
        avs_address <= a;
        avs_writedata <= {24'h0, d};
        avs_write <= wr;
        avs_read <= !wr;
        n = 0;
        do
        begin
            @(posedge mclk);
            n++;
        end
        while (avs_waitrequest !== 1'b0 && n < 100);
        if (n >= 100)
            n_errors++;
        rd_v = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask : bus
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        bus(1'b1, a, d);
    endtask : wr
    task automatic rdc(input logic [2:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00);
        chk(rd_v, {24'h0, e});
    endtask : rdc
    task automatic tick(input int k);
        repeat (k) @(posedge mclk);
    endtask : tick
    task automatic wrap_up();
        $display("checks=%0d errors=%0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : wrap_up
    // Main sequence
    initial
    begin
        repeat (4) @(posedge mclk);
        reset <= 1'b0;
        tick(2);
        chk({ctl.cpu_div, ctl.onchip_sel}, 4'h7);
        chk({ctl.main_buf_en, ctl.main_clk_pass, pins_in}, 3'h1);
        for (int i = 0; i < 8; i++) rdc(3'(i), rst_tab[i]);
        wr(`CSD_IDX_CTRL_B, 8'h08);
        rdc(`CSD_IDX_CTRL_B, 8'h20);
        wr(`CSD_IDX_OSD, 8'h00);
        rdc(`CSD_IDX_OSD, 8'h04);
        wr(`CSD_IDX_VDPE, 8'he0);
        rdc(`CSD_IDX_VDPE, 8'h00);
        wr(`CSD_IDX_PROTECT, 8'h01);
        wr(`CSD_IDX_CTRL_B, 8'h28);
        wr(`CSD_IDX_CTRL_B, 8'h20);
        rdc(`CSD_IDX_CTRL_B, 8'h28);
        tick(2);
        chk({ctl.main_clk_pass, ctl.main_buf_en, pins_in}, 3'h4);
        wr(`CSD_IDX_CTRL_B, 8'he8);
        tick(2);
        chk(ctl.cpu_div, csd_pkg::CSD_DIV8);
        wr(`CSD_IDX_CTRL_A, 8'h00);
        pin_run <= 1'b1;
        tick(20);
        chk({ctl.cpu_div == csd_pkg::CSD_DIV8, ctl.main_buf_en}, 2'h1);
        wr(`CSD_IDX_OSD, 8'h00);
        rdc(`CSD_IDX_CTRL_B, 8'hf8);
        wr(`CSD_IDX_OSD, 8'h04);
        wr(`CSD_IDX_CTRL_B, 8'hf8);
        rdc(`CSD_IDX_CTRL_B, 8'he8);
        // Watchdog protect blocks writes to all-stop and low-speed stop
        wr(`CSD_IDX_OSD, 8'h00);
        wdt <= 1'b1;
        wr(`CSD_IDX_CTRL_B, 8'he9);
        rdc(`CSD_IDX_CTRL_B, 8'hf8);
        wdt <= 1'b0;
        // Stop detection, then a lost main clock
        wr(`CSD_IDX_OSD, 8'h03);
        tick(TMO + 4);
        rdc(`CSD_IDX_OSD, 8'h03);
        chk(irq_en, 1'b1);
        pin_run <= 1'b0;
        tick(TMO + 8);
        rdc(`CSD_IDX_OSD, 8'h0f);
        rdc(`CSD_IDX_CTRL_B, 8'he8);
        wr(`CSD_IDX_OSD, 8'h0b);
        rdc(`CSD_IDX_OSD, 8'h0f);
        wr(`CSD_IDX_OSD, 8'h04);
        rdc(`CSD_IDX_OSD, 8'h04);
        wr(`CSD_IDX_FAST_A, 8'h03);
        tick(2);
        chk({ctl.fast_osc_en, ctl.onchip_fast}, 2'h3);
        wr(`CSD_IDX_FAST_A, 8'h00);
        // Stop mode entry with drive low, then wake
        wr(`CSD_IDX_CTRL_B, 8'hc8);
        wr(`CSD_IDX_CTRL_B, 8'hc9);
        tick(2);
        chk({ctl.stop_mode, ctl.drive_high, ctl.feedback_en}, 3'h6);
        chk({pin_o, oe_n}, 2'h2);
        chk({ctl.main_buf_en, ctl.main_clk_pass, ctl.low_osc_en}, 3'h0);
        rdc(`CSD_IDX_CTRL_A, 8'h40);
        rdc(`CSD_IDX_CTRL_B, 8'he9);
        wake <= 1'b1;
        tick(1);
        wake <= 1'b0;
        tick(3);
        chk({ctl.stop_mode, oe_n}, 2'h1);
        // Voltage monitors wait out the settling delay
        wr(`CSD_IDX_PROTECT, 8'h08);
        wr(`CSD_IDX_VDPE, 8'he0);
        tick(DET - 1);
        chk(mon, 3'h0);
        n = 0;
        while (mon !== 3'h7 && n < 20)
        begin
            tick(1);
            n++;
        end
        chk(mon, 3'h7);
        rdc(`CSD_IDX_VDPE, 8'he0);
        wrap_up();
    end
    // Watchdog against a hang
    initial
    begin
        #120000;
        n_errors++;
        wrap_up();
    end
endmodule : tb_csd_clock_ctrl
